// ---- src/oob_consts.svh ----
`ifndef OOB_CONSTS_SVH
`define OOB_CONSTS_SVH

// ********************************************************
// clock and printed times, in picoseconds
// ********************************************************
`define OOB_CLK_PS 40000
`define OOB_T_BURST_PS 106700
`define OOB_T_RST_GAP_PS 320000
`define OOB_T_WAKE_GAP_PS 106700
`define OOB_T_RST_MIN_PS 175000
`define OOB_T_RST_MAX_PS 525000
`define OOB_T_WAKE_MIN_PS 35000
`define OOB_T_WAKE_MAX_PS 175000
`define OOB_T_WAKE_TAIL_MAX_PS 228300
`define OOB_T_SPEED_PS 54600000
`define OOB_T_HOST_WAIT_PS 873800000

// ********************************************************
// cycle counts derived from the times
// ********************************************************
`define OOB_CEIL(t) (((t) + `OOB_CLK_PS - 1) / `OOB_CLK_PS)
`define OOB_FLOOR(t) ((t) / `OOB_CLK_PS)
`define OOB_BURST_CYC `OOB_CEIL(`OOB_T_BURST_PS)
`define OOB_RST_GAP_CYC `OOB_CEIL(`OOB_T_RST_GAP_PS)
`define OOB_WAKE_GAP_CYC `OOB_CEIL(`OOB_T_WAKE_GAP_PS)
`define OOB_RST_MIN_CYC `OOB_CEIL(`OOB_T_RST_MIN_PS)
`define OOB_RST_MAX_CYC `OOB_FLOOR(`OOB_T_RST_MAX_PS)
`define OOB_WAKE_MIN_CYC `OOB_CEIL(`OOB_T_WAKE_MIN_PS)
`define OOB_WAKE_MAX_CYC `OOB_FLOOR(`OOB_T_WAKE_MAX_PS)
`define OOB_RST_TAIL_CYC `OOB_CEIL(`OOB_T_RST_MAX_PS)
`define OOB_WAKE_TAIL_CYC `OOB_FLOOR(`OOB_T_WAKE_TAIL_MAX_PS)
`define OOB_SPEED_CYC `OOB_FLOOR(`OOB_T_SPEED_PS)
`define OOB_HOST_WAIT_CYC `OOB_CEIL(`OOB_T_HOST_WAIT_PS)

// ********************************************************
// counts of events
// ********************************************************
`define OOB_MIN_BURSTS 6
`define OOB_DET_GAPS 3
`define OOB_RUN_LEN 3
`define OOB_IDLE_SAT 31

`endif

// ---- src/oob_pkg.sv ----
package oob_pkg;
`include "oob_consts.svh"

  typedef enum logic [1:0] {
    PRIM_NONE = 2'h0,
    PRIM_D10 = 2'h1,
    PRIM_ALIGN = 2'h2,
    PRIM_SYNC = 2'h3
  } oob_prim_t;

  typedef enum logic {
    KIND_LONG = 1'h0,
    KIND_WAKE = 1'h1
  } oob_kind_t;

  typedef logic [1:0] oob_speed_t;

  typedef enum logic [8:0] {
    DS_RESET = 9'h001,
    DS_INIT = 9'h002,
    DS_WAIT_WAKE = 9'h004,
    DS_WAKE = 9'h008,
    DS_ALIGN = 9'h010,
    DS_SYNC = 9'h020,
    DS_READY = 9'h040,
    DS_SLEEP = 9'h080,
    DS_ERROR = 9'h100
  } oob_dev_state_t;

  typedef enum logic [7:0] {
    HS_HRST = 8'h01,
    HS_WAIT_INIT = 8'h02,
    HS_WAKE = 8'h04,
    HS_WAIT_DWAKE = 8'h08,
    HS_D10 = 8'h10,
    HS_ALIGN = 8'h20,
    HS_READY = 8'h40,
    HS_STOP = 8'h80
  } oob_host_state_t;

  function automatic logic [15:0] oob_gap_cyc(input oob_kind_t k);
    return (k == KIND_WAKE) ? 16'(`OOB_WAKE_GAP_CYC) : 16'(`OOB_RST_GAP_CYC);
  endfunction

  function automatic logic [15:0] oob_tail_cyc(input oob_kind_t k);
    return (k == KIND_WAKE) ? 16'(`OOB_WAKE_TAIL_CYC) : 16'(`OOB_RST_TAIL_CYC);
  endfunction

  function automatic logic oob_in_win(input logic [4:0] idle, input oob_kind_t k);
    if (k == KIND_WAKE) begin
      return idle >= 5'(`OOB_WAKE_MIN_CYC) && idle <= 5'(`OOB_WAKE_MAX_CYC);
    end
    return idle >= 5'(`OOB_RST_MIN_CYC) && idle <= 5'(`OOB_RST_MAX_CYC);
  endfunction

  function automatic logic [1:0] oob_sat_inc(input logic [1:0] c);
    return (c == 2'h3) ? c : c + 2'h1;
  endfunction

  // idle or alignment breaks the run
  function automatic logic [1:0] oob_run_next(input logic [1:0] c, input oob_prim_t p);
    return (p == PRIM_NONE || p == PRIM_ALIGN) ? 2'h0 : oob_sat_inc(c);
  endfunction
endpackage

// ---- src/oob_link_if.sv ----
`timescale 1ns/100ps
interface oob_link_if import oob_pkg::*; ();
  logic h2d_burst;
  oob_prim_t h2d_prim;
  oob_speed_t h2d_speed;
  logic d2h_burst;
  oob_prim_t d2h_prim;
  oob_speed_t d2h_speed;

  modport host (
    output h2d_burst, h2d_prim, h2d_speed,
    input d2h_burst, d2h_prim, d2h_speed
  );
  modport dev (
    input h2d_burst, h2d_prim, h2d_speed,
    output d2h_burst, d2h_prim, d2h_speed
  );
endinterface

// ---- src/oob_dev.sv ----
`timescale 1ns/100ps
`include "oob_consts.svh"

// ********************************************************
// burst train generator
// ********************************************************
module oob_tx import oob_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire oob_kind_t kind_i,
  input wire logic cont_i,
  output logic line_o,
  output logic busy_o,
  output logic done_o
);
  logic [15:0] ph;
  logic [2:0] nb;
  oob_kind_t kind;

  wire logic last = nb >= 3'(`OOB_MIN_BURSTS);
  wire logic [15:0] gap = oob_gap_cyc(kind);
  wire logic [15:0] tail = oob_tail_cyc(kind);
  wire logic burst_end = line_o && ph == 16'(`OOB_BURST_CYC - 1);
  wire logic gap_end = !line_o && (!last || cont_i) && ph == gap - 16'h0001;
  assign done_o = busy_o && !line_o && last && !cont_i && ph == tail - 16'h0001;

  // a new start aborts any train in flight
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_o <= 1'b0;
      busy_o <= 1'b0;
      ph <= 16'h0000;
      nb <= 3'h0;
      kind <= KIND_LONG;
    end else if (ce_i) begin
      if (start_i) begin
        kind <= kind_i;
        busy_o <= 1'b1;
        line_o <= 1'b1;
        ph <= 16'h0000;
        nb <= 3'h0;
      end else if (busy_o) begin
        if (burst_end) begin
          line_o <= 1'b0;
          ph <= 16'h0000;
          nb <= last ? nb : nb + 3'h1;
        end else if (gap_end) begin
          line_o <= 1'b1;
          ph <= 16'h0000;
        end else if (done_o) begin
          busy_o <= 1'b0;
          ph <= 16'h0000;
        end else begin
          ph <= ph + 16'h0001;
        end
      end
    end
  end
endmodule

// ********************************************************
// burst spacing detector
// ********************************************************
module oob_det import oob_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic line_i,
  output logic long_det_o,
  output logic long_end_o,
  output logic wake_det_o,
  output logic wake_end_o
);
  logic s1;
  logic s2;
  logic s3;
  logic [4:0] idle;
  logic [1:0] lng;
  logic [1:0] wk;
  logic lng_q;
  logic wk_q;

  wire logic rise = s2 && !s3;
  assign long_det_o = lng == 2'(`OOB_DET_GAPS);
  assign wake_det_o = wk == 2'(`OOB_DET_GAPS);
  assign long_end_o = lng_q && !long_det_o;
  assign wake_end_o = wk_q && !wake_det_o;

  // burst length is never checked, only the idle run before each rise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      idle <= 5'h1f;
      lng <= 2'h0;
      wk <= 2'h0;
      lng_q <= 1'b0;
      wk_q <= 1'b0;
    end else if (ce_i) begin
      s1 <= line_i;
      s2 <= s1;
      s3 <= s2;
      if (s2) begin
        idle <= 5'h00;
      end else if (idle != 5'(`OOB_IDLE_SAT)) begin
        idle <= idle + 5'h01;
      end
      if (rise) begin
        lng <= oob_in_win(idle, KIND_LONG) ? oob_sat_inc(lng) : 2'h0;
        wk <= oob_in_win(idle, KIND_WAKE) ? oob_sat_inc(wk) : 2'h0;
      end else begin
        if (idle > 5'(`OOB_RST_MAX_CYC)) begin
          lng <= 2'h0;
        end
        if (idle > 5'(`OOB_WAKE_MAX_CYC)) begin
          wk <= 2'h0;
        end
      end
      lng_q <= long_det_o;
      wk_q <= wake_det_o;
    end
  end
endmodule

// ********************************************************
// device end
// ********************************************************
module oob_dev import oob_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  oob_link_if.dev link,
  input wire oob_speed_t max_speed_i,
  input wire logic init_req_i,
  input wire logic sleep_req_i,
  output logic hw_reset_o,
  output logic link_up_o,
  output logic sleep_o,
  output logic err_o,
  output oob_speed_t speed_o
);
  oob_dev_state_t state;
  oob_dev_state_t next_state;
  oob_speed_t speed;
  oob_prim_t prim;
  logic [15:0] timer;
  logic [1:0] run;
  logic boot;
  logic tx_line;
  logic tx_done;
  logic long_det;
  logic long_end;
  logic wake_det;
  logic wake_end;

  wire logic tmo = timer == 16'(`OOB_SPEED_CYC - 1);
  wire logic align_seen = link.h2d_prim == PRIM_ALIGN && link.h2d_speed == speed;
  wire logic entering = next_state != state;
  wire logic tx_start = boot || (entering && (next_state == DS_INIT || next_state == DS_WAKE));
  wire oob_kind_t tx_kind = (next_state == DS_WAKE) ? KIND_WAKE : KIND_LONG;
  wire logic init_ok = state != DS_RESET && state != DS_INIT;
  wire oob_prim_t next_prim = (next_state == DS_ALIGN) ? PRIM_ALIGN :
      (next_state == DS_SYNC || next_state == DS_READY) ? PRIM_SYNC : PRIM_NONE;

  assign link.d2h_burst = tx_line;
  assign link.d2h_prim = prim;
  assign link.d2h_speed = speed;
  assign hw_reset_o = state == DS_RESET;
  assign link_up_o = state == DS_READY;
  assign sleep_o = state == DS_SLEEP;
  assign err_o = state == DS_ERROR;
  assign speed_o = speed;

  oob_tx u_tx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(tx_start),
    .kind_i(tx_kind),
    .cont_i(1'b0),
    .line_o(tx_line),
    .busy_o(),
    .done_o(tx_done)
  );

  oob_det u_det (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .line_i(link.h2d_burst),
    .long_det_o(long_det),
    .long_end_o(long_end),
    .wake_det_o(wake_det),
    .wake_end_o(wake_end)
  );

  always_comb begin
    next_state = state;
    case (state)
      DS_RESET: begin
        if (long_end) next_state = DS_INIT;
      end
      DS_INIT: begin
        if (tx_done) next_state = DS_WAIT_WAKE;
      end
      DS_WAIT_WAKE: begin
        if (wake_end) next_state = DS_WAKE;
      end
      DS_WAKE: begin
        if (tx_done) next_state = DS_ALIGN;
      end
      DS_ALIGN: begin
        if (align_seen) next_state = DS_SYNC;
        else if (tmo && speed == 2'h0) next_state = DS_ERROR;
      end
      DS_SYNC: begin
        if (run == 2'(`OOB_RUN_LEN)) next_state = DS_READY;
      end
      DS_READY: begin
        if (sleep_req_i) next_state = DS_SLEEP;
      end
      DS_SLEEP: begin
        if (wake_det) next_state = DS_WAIT_WAKE;
      end
      DS_ERROR: begin
        next_state = DS_ERROR;
      end
      default: begin
        next_state = DS_RESET;
      end
    endcase
    // software may ask for a host reset in any state but DS_RESET and DS_INIT
    if (init_req_i && init_ok) next_state = DS_INIT;
    if (long_det) next_state = DS_RESET;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= DS_INIT;
      boot <= 1'b1;
      speed <= 2'h0;
      prim <= PRIM_NONE;
      timer <= 16'h0000;
      run <= 2'h0;
    end else if (ce_i) begin
      state <= next_state;
      boot <= 1'b0;
      prim <= next_prim;
      run <= oob_run_next(run, link.h2d_prim);
      timer <= (entering || tmo) ? 16'h0000 : timer + 16'h0001;
      if (state == DS_WAKE && next_state == DS_ALIGN) begin
        speed <= max_speed_i;
      end else if (state == DS_ALIGN && tmo && !align_seen && speed != 2'h0) begin
        speed <= speed - 2'h1;
      end
    end
  end
endmodule

// ---- src/oob_host.sv ----
`timescale 1ns/100ps
`include "oob_consts.svh"

// ********************************************************
// host end
// ********************************************************
module oob_host import oob_pkg::*; #(
  parameter int HOST_WAIT_CYC = `OOB_HOST_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  oob_link_if.host link,
  input wire logic sys_hrst_i,
  input wire logic stop_i,
  output logic link_up_o,
  output oob_speed_t speed_o
);
  oob_host_state_t state;
  oob_host_state_t next_state;
  oob_speed_t speed;
  oob_prim_t prim;
  logic [15:0] timer;
  logic [1:0] run;
  logic boot;
  logic tx_line;
  logic tx_done;
  logic long_end;
  logic wake_end;

  wire logic tmo = timer == 16'(HOST_WAIT_CYC - 1);
  wire logic align_rx = link.d2h_prim == PRIM_ALIGN;
  wire logic entering = next_state != state;
  wire logic tx_start = boot || (entering && (next_state == HS_HRST || next_state == HS_WAKE));
  wire oob_kind_t tx_kind = (next_state == HS_WAKE) ? KIND_WAKE : KIND_LONG;
  wire logic tx_cont = sys_hrst_i && (boot || next_state == HS_HRST);
  // the long_end restart to HS_WAKE is gated off in HS_HRST, HS_WAIT_INIT and HS_WAKE
  wire logic rx_ok = state != HS_HRST && state != HS_WAIT_INIT && state != HS_WAKE;
  wire oob_prim_t next_prim = (next_state == HS_D10) ? PRIM_D10 :
      (next_state == HS_ALIGN) ? PRIM_ALIGN :
      (next_state == HS_READY) ? PRIM_SYNC : PRIM_NONE;

  assign link.h2d_burst = tx_line;
  assign link.h2d_prim = prim;
  assign link.h2d_speed = speed;
  assign link_up_o = state == HS_READY;
  assign speed_o = speed;

  oob_tx u_tx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(tx_start),
    .kind_i(tx_kind),
    .cont_i(tx_cont),
    .line_o(tx_line),
    .busy_o(),
    .done_o(tx_done)
  );

  oob_det u_det (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .line_i(link.d2h_burst),
    .long_det_o(),
    .long_end_o(long_end),
    .wake_det_o(),
    .wake_end_o(wake_end)
  );

  always_comb begin
    next_state = state;
    case (state)
      HS_HRST: begin
        if (tx_done) next_state = HS_WAIT_INIT;
      end
      HS_WAIT_INIT: begin
        if (long_end) next_state = HS_WAKE;
      end
      HS_WAKE: begin
        if (tx_done) next_state = HS_WAIT_DWAKE;
      end
      HS_WAIT_DWAKE: begin
        if (wake_end) next_state = HS_D10;
      end
      HS_D10: begin
        if (align_rx) next_state = HS_ALIGN;
        else if (tmo) next_state = stop_i ? HS_STOP : HS_HRST;
      end
      HS_ALIGN: begin
        if (run == 2'(`OOB_RUN_LEN)) next_state = HS_READY;
      end
      HS_READY: begin
        next_state = HS_READY;
      end
      HS_STOP: begin
        if (!stop_i) next_state = HS_HRST;
      end
      default: begin
        next_state = HS_HRST;
      end
    endcase
    if (long_end && rx_ok) next_state = HS_WAKE;
    if (sys_hrst_i) next_state = HS_HRST;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= HS_HRST;
      boot <= 1'b1;
      speed <= 2'h0;
      prim <= PRIM_NONE;
      timer <= 16'h0000;
      run <= 2'h0;
    end else if (ce_i) begin
      state <= next_state;
      boot <= 1'b0;
      prim <= next_prim;
      run <= oob_run_next(run, link.d2h_prim);
      timer <= entering ? 16'h0000 : timer + 16'h0001;
      if (state == HS_WAIT_DWAKE) begin
        speed <= 2'h0;
      end else if ((state == HS_D10 || state == HS_ALIGN) && align_rx) begin
        speed <= link.d2h_speed;
      end
    end
  end
endmodule

// ---- test/oob_link_asserts.sv ----
`timescale 1ns/100ps
module oob_link_asserts import oob_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic h2d_burst,
  input wire oob_prim_t h2d_prim,
  input wire oob_speed_t h2d_speed,
  input wire logic d2h_burst,
  input wire oob_prim_t d2h_prim,
  input wire oob_speed_t d2h_speed
);
  logic [7:0] idle_h;
  logic [7:0] idle_d;
  logic [3:0] nb_h;
  wire rise_h = h2d_burst && idle_h != 8'h00 && nb_h != 4'hf;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ********
  // idle run and burst count
  // ********
  // counts saturate so a long quiet line never wraps into a legal gap
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_h <= 8'hff;
      idle_d <= 8'hff;
      nb_h <= 4'h0;
    end else begin
      idle_h <= h2d_burst ? 8'h00 : idle_h + {7'h00, idle_h != 8'hff};
      idle_d <= d2h_burst ? 8'h00 : idle_d + {7'h00, idle_d != 8'hff};
      nb_h <= (idle_h == 8'h0a) ? 4'h0 : nb_h + {3'h0, rise_h};
    end
  end

  // ********
  // properties
  // ********
  sequence s_burst(b);
    b [*3] ##1 !b;
  endsequence
  sequence s_rise_align;
    $rose(d2h_prim == PRIM_ALIGN);
  endsequence
  property p_burst_h;
    $rose(h2d_burst) |-> s_burst(h2d_burst);
  endproperty
  property p_burst_d;
    $rose(d2h_burst) |-> s_burst(d2h_burst);
  endproperty
  property p_gap_h;
    $rose(h2d_burst) |-> idle_h == 8'h03 || idle_h == 8'h08 || idle_h >= 8'h0e;
  endproperty
  property p_gap_d;
    $rose(d2h_burst) |-> idle_d == 8'h03 || idle_d == 8'h08 || idle_d >= 8'h0e;
  endproperty
  property p_six_h;
    idle_h == 8'h09 |-> nb_h >= 4'h6;
  endproperty
  property p_wake_tail_d;
    s_rise_align |-> idle_d >= 8'h05 && idle_d <= 8'h07;
  endproperty
  property p_dev_sync;
    $rose(d2h_prim == PRIM_SYNC) |-> h2d_prim == PRIM_ALIGN;
  endproperty
  property p_host_align;
    $rose(h2d_prim == PRIM_ALIGN) |-> d2h_prim == PRIM_ALIGN && h2d_speed == d2h_speed;
  endproperty

  a_burst_h: assert property (p_burst_h) else $error("host burst length wrong");
  a_burst_d: assert property (p_burst_d) else $error("device burst length wrong");
  a_gap_h: assert property (p_gap_h) else $error("host burst spacing wrong");
  a_gap_d: assert property (p_gap_d) else $error("device burst spacing wrong");
  a_six_h: assert property (p_six_h) else $error("host train too short");
  a_wake_tail_d: assert property (p_wake_tail_d) else $error("device wake tail wrong");
  a_dev_sync: assert property (p_dev_sync) else $error("device sync without host align");
  a_host_align: assert property (p_host_align) else $error("host align speed wrong");
endmodule

// ---- test/oob_signaling_link_init_test.sv ----
`timescale 1ns/100ps
module oob_signaling_link_init_test import oob_pkg::*; ();
  logic clk_i;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic dev_ce = 1'b0;
  logic sys_hrst = 1'b1;
  logic init_req = 1'b0;
  logic sleep_req = 1'b0;
  logic h_up, d_up, d_hrst, d_slp, hrst2, err2, up2, slp2;
  logic hr_seen = 1'b0;
  logic hr2_seen = 1'b0;
  oob_speed_t mx1, mx2, h_spd, d_spd, spd2, e;
  oob_speed_t q[$];
  int n;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  // ********
  // two ends face to face, and a lone device on a bench-driven link
  // ********
  oob_link_if lnk();
  oob_link_if lnk2();
  oob_host #(.HOST_WAIT_CYC(200)) u_oob_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .link(lnk), .sys_hrst_i(sys_hrst), .stop_i(1'b0), .link_up_o(h_up), .speed_o(h_spd));
  oob_dev u_oob_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(dev_ce), .link(lnk),
    .max_speed_i(mx1), .init_req_i(init_req), .sleep_req_i(sleep_req), .hw_reset_o(d_hrst),
    .link_up_o(d_up), .sleep_o(d_slp), .err_o(), .speed_o(d_spd));
  oob_dev u_oob_dev_b (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .link(lnk2),
    .max_speed_i(mx2), .init_req_i(init_req), .sleep_req_i(sleep_req), .hw_reset_o(hrst2),
    .link_up_o(up2), .sleep_o(slp2), .err_o(err2), .speed_o(spd2));
  oob_link_asserts u_oob_link_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .h2d_burst(lnk.h2d_burst), .h2d_prim(lnk.h2d_prim), .h2d_speed(lnk.h2d_speed),
    .d2h_burst(lnk.d2h_burst), .d2h_prim(lnk.d2h_prim), .d2h_speed(lnk.d2h_speed));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (d_hrst === 1'b1) hr_seen = 1'b1;
    if (hrst2 === 1'b1) hr2_seen = 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ********
  // helpers
  // ********
  task automatic tk(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_spd(input oob_speed_t got, input oob_speed_t exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_up();
    n = 0;
    while (!(h_up === 1'b1 && d_up === 1'b1) && n < 3000) begin
      tk(1);
      n++;
    end
  endtask

  task automatic pulse_init();
    init_req = 1'b1;
    tk(1);
    init_req = 1'b0;
  endtask

  // six bursts, then a quiet tail long enough to end any detection
  task automatic send_train(input int gap);
    for (int i = 0; i < 6; i++) begin
      lnk2.h2d_burst = 1'b1;
      tk(3);
      lnk2.h2d_burst = 1'b0;
      tk(gap);
    end
    tk(20);
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ********
  // scenarios
  // ********
  initial begin
    void'($urandom(6793));
    mx1 = oob_speed_t'($urandom_range(3, 0));
    mx2 = oob_speed_t'($urandom_range(3, 1));
    lnk2.h2d_burst = 1'b0;
    lnk2.h2d_prim = PRIM_D10;
    lnk2.h2d_speed = 2'h0;
    tk(5);
    rst_n_i = 1'b1;
    tk(20);
    sys_hrst = 1'b0;
    // device frozen until the reset train is over, so it joins as a late starter
    tk(120);
    dev_ce = 1'b1;
    wait_up();
    chk_bit(h_up, 1'b1);
    chk_bit(d_up, 1'b1);
    chk_spd(d_spd, mx1);
    chk_spd(h_spd, mx1);
    send_train(16 + $urandom_range(4, 0));
    chk_bit(hr2_seen, 1'b0);
    send_train(5 + $urandom_range(8, 0));
    chk_bit(hr2_seen, 1'b1);
    tk(150);
    send_train(1 + $urandom_range(3, 0));
    for (int s = int'(mx2); s >= 0; s--) q.push_back(oob_speed_t'(s));
    n = 0;
    while (lnk2.d2h_prim !== PRIM_ALIGN && n < 400) begin
      tk(1);
      n++;
    end
    e = q.pop_front();
    chk_spd(spd2, e);
    while (q.size() > 0) begin
      n = 0;
      while (spd2 === e && n < 1500) begin
        tk(1);
        n++;
      end
      e = q.pop_front();
      chk_spd(spd2, e);
    end
    n = 0;
    while (err2 !== 1'b1 && n < 1500) begin
      tk(1);
      n++;
    end
    chk_bit(err2, 1'b1);
    chk_bit(n >= 1364 && n <= 1367, 1'b1);
    hr_seen = 1'b0;
    pulse_init();
    tk(10);
    chk_bit(d_up, 1'b0);
    wait_up();
    chk_bit(h_up & d_up, 1'b1);
    chk_bit(hr_seen, 1'b0);
    sleep_req = 1'b1;
    tk(4);
    sleep_req = 1'b0;
    chk_bit(d_slp, 1'b1);
    pulse_init();
    wait_up();
    chk_bit(d_slp, 1'b0);
    chk_spd(h_spd, mx1);
    sys_hrst = 1'b1;
    tk(100);
    chk_bit(h_up, 1'b0);
    sys_hrst = 1'b0;
    wait_up();
    chk_bit(hr_seen, 1'b1);
    chk_bit(d_up, 1'b1);
    // lone device: bench plays host through link-up, sleep and a wake from sleep
    send_train(1 + $urandom_range(3, 0));
    n = 0;
    while (lnk2.d2h_prim !== PRIM_ALIGN && n < 400) begin
      tk(1);
      n++;
    end
    chk_spd(spd2, mx2);
    lnk2.h2d_speed = mx2;
    lnk2.h2d_prim = PRIM_ALIGN;
    tk(2);
    lnk2.h2d_prim = PRIM_SYNC;
    tk(6);
    chk_bit(up2, 1'b1);
    sleep_req = 1'b1;
    tk(4);
    sleep_req = 1'b0;
    chk_bit(slp2, 1'b1);
    send_train(1 + $urandom_range(3, 0));
    chk_bit(slp2, 1'b0);
    n = 0;
    while (lnk2.d2h_prim !== PRIM_ALIGN && n < 400) begin
      tk(1);
      n++;
    end
    chk_bit(lnk2.d2h_prim === PRIM_ALIGN, 1'b1);
    chk_spd(spd2, mx2);
    complete_run();
  end
endmodule
